/* verilog/simultaneous_sample_conv_control.v */
// Conversion, power-mode and parallel readout control for a four-channel converter.
`timescale 1ns/1ps
`default_nettype none
`include "conv_ctrl_consts.vh"
module simultaneous_sample_conv_control (
  input wire i_clk,
  input wire i_nrst,
  input wire i_power_save_n,
  input wire i_range,
  input wire i_sample_trigger_a,
  input wire i_sample_trigger_b,
  input wire i_cs_n,
  input wire i_rd_n,
  input wire [`DATA_W-1:0] i_ch1_data,
  input wire [`DATA_W-1:0] i_ch2_data,
  input wire [`DATA_W-1:0] i_ch3_data,
  input wire [`DATA_W-1:0] i_ch4_data,
  output wire o_standby,
  output wire o_shutdown,
  output wire o_front_end_on,
  output wire o_reference_on,
  output wire o_hold_a,
  output wire o_hold_b,
  output reg o_busy,
  output reg [`DATA_W-1:0] o_parallel_out_bus,
  output wire o_parallel_out_bus_oe,
  output reg o_first_channel_flag,
  output wire o_first_channel_flag_oe
);
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_CONV = 2'b01;
  localparam [1:0] ST_DONE = 2'b10;
  localparam integer CONV_LAST_INT = `CONV_CYCLES - 1;
  localparam [`CONV_CNT_W-1:0] CONV_LAST = CONV_LAST_INT[`CONV_CNT_W-1:0];

  wire pd_async;
  wire trig_a_lvl;
  wire trig_a_rise;
  wire trig_b_lvl;
  wire trig_b_rise;
  wire cs_lvl;
  wire cs_fall;
  wire rd_lvl;
  wire rd_fall;
  wire strobe_fall;
  wire pd_sync;
  wire conv_end;
  reg pd_meta_reg;
  reg pd_sync_reg;
  reg range_meta_reg;
  reg range_sync_reg;
  reg [1:0] state_reg;
  reg hold_a_reg;
  reg hold_b_reg;
  reg [`CONV_CNT_W-1:0] conv_cnt_reg;
  reg [`DATA_W-1:0] sample_mem [0:`CH_COUNT-1];
  reg [`DATA_W-1:0] result_mem [0:`CH_COUNT-1];
  reg [`CH_IDX_W-1:0] ch_idx_reg;
  reg bus_active_reg;
  integer k;

  // Shutdown decode is shared by the mode output and the reference enable.
  function shutdown_sel;
    input power_save_n;
    input range;
    begin
      shutdown_sel = ~power_save_n & ~range;
    end
  endfunction

  // Channel pointer steps upward and wraps from the last channel to the first.
  function [`CH_IDX_W-1:0] next_ch;
    input [`CH_IDX_W-1:0] idx;
    begin
      if (idx == `CH_LAST) begin
        next_ch = `CH_FIRST;
      end else begin
        next_ch = idx + 1'b1;
      end
    end
  endfunction

  // Power-down entry is a pure decode of the pins, so it acts with no clock.
  assign pd_async = ~i_power_save_n;
  assign o_standby = pd_async & i_range;
  assign o_shutdown = shutdown_sel(i_power_save_n, i_range);
  assign o_front_end_on = ~pd_async;
  assign o_reference_on = ~shutdown_sel(i_power_save_n, i_range);
  assign o_hold_a = hold_a_reg;
  assign o_hold_b = hold_b_reg;

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pd_meta_reg <= 1'b0;
      pd_sync_reg <= 1'b0;
      range_meta_reg <= 1'b0;
      range_sync_reg <= 1'b0;
    end else begin
      pd_meta_reg <= pd_async;
      pd_sync_reg <= pd_meta_reg;
      range_meta_reg <= i_range;
      range_sync_reg <= range_meta_reg;
    end
  end
  assign pd_sync = pd_sync_reg;
  // Last counted cycle of a conversion; busy then spans exactly the maximum conversion time.
  assign conv_end = (state_reg == ST_CONV) && (conv_cnt_reg == CONV_LAST) && !pd_sync;

  edge_sync u_trig_a (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_rst_level(1'b0),
    .i_async(i_sample_trigger_a),
    .o_level(trig_a_lvl),
    .o_rise(trig_a_rise),
    .o_fall()
  );

  edge_sync u_trig_b (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_rst_level(1'b0),
    .i_async(i_sample_trigger_b),
    .o_level(trig_b_lvl),
    .o_rise(trig_b_rise),
    .o_fall()
  );

  edge_sync u_cs (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_rst_level(1'b0),
    .i_async(~i_cs_n),
    .o_level(cs_lvl),
    .o_rise(cs_fall),
    .o_fall()
  );

  edge_sync u_rd (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_rst_level(1'b0),
    .i_async(~i_rd_n),
    .o_level(rd_lvl),
    .o_rise(rd_fall),
    .o_fall()
  );

  // A read step is a fall of read while select is low, or both falling together.
  assign strobe_fall = rd_fall & (cs_lvl | cs_fall);

  // Sampling and conversion sequencer.
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= ST_IDLE;
      hold_a_reg <= 1'b0;
      hold_b_reg <= 1'b0;
      conv_cnt_reg <= {`CONV_CNT_W{1'b0}};
      o_busy <= 1'b0;
      for (k = 0; k < `CH_COUNT; k = k + 1) begin
        sample_mem[k] <= `DATA_RST;
        result_mem[k] <= `DATA_RST;
      end
    end else if (pd_sync) begin
      state_reg <= ST_IDLE;
      hold_a_reg <= 1'b0;
      hold_b_reg <= 1'b0;
      o_busy <= 1'b0;
      conv_cnt_reg <= {`CONV_CNT_W{1'b0}};
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // With both triggers tied, one rise holds all four channels at once.
          if (trig_a_rise && !hold_a_reg) begin
            hold_a_reg <= 1'b1;
            sample_mem[0] <= i_ch1_data;
            sample_mem[1] <= i_ch2_data;
          end
          if (trig_b_rise && !hold_b_reg) begin
            hold_b_reg <= 1'b1;
            sample_mem[2] <= i_ch3_data;
            sample_mem[3] <= i_ch4_data;
          end
          if ((hold_a_reg | trig_a_rise) & (hold_b_reg | trig_b_rise)) begin
            state_reg <= ST_CONV;
            o_busy <= 1'b1;
            conv_cnt_reg <= {`CONV_CNT_W{1'b0}};
          end
        end
        ST_CONV: begin
          // Trigger edges are not looked at here.
          if (conv_end) begin
            for (k = 0; k < `CH_COUNT; k = k + 1) begin
              result_mem[k] <= sample_mem[k];
            end
            // Busy falls on the edge that loads the results, so its fall marks valid data.
            o_busy <= 1'b0;
            hold_a_reg <= 1'b0;
            hold_b_reg <= 1'b0;
            state_reg <= ST_DONE;
          end else begin
            conv_cnt_reg <= conv_cnt_reg + 1'b1;
          end
        end
        ST_DONE: begin
          // One settling cycle after busy falls; a trigger edge inside it is dropped.
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Readout sequencer: results only change on busy falling, so reads in busy see old data.
  // With select and read tied, the strobes rise between channels, so the channel
  // pointer survives those gaps and returns to channel 1 when a conversion ends or after channel 4 is read.
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ch_idx_reg <= `CH_FIRST;
      bus_active_reg <= 1'b0;
      o_parallel_out_bus <= `DATA_RST;
      o_first_channel_flag <= 1'b0;
    end else begin
      if (!cs_lvl && !rd_lvl) begin
        bus_active_reg <= 1'b0;
        o_first_channel_flag <= 1'b0;
      end else if (cs_fall) begin
        bus_active_reg <= 1'b1;
      end
      if (strobe_fall) begin
        bus_active_reg <= 1'b1;
        o_parallel_out_bus <= result_mem[ch_idx_reg];
        o_first_channel_flag <= (ch_idx_reg == `CH_FIRST);
        ch_idx_reg <= next_ch(ch_idx_reg);
      end
      if (conv_end) begin
        ch_idx_reg <= `CH_FIRST;
      end
    end
  end

  assign o_parallel_out_bus_oe = bus_active_reg;
  assign o_first_channel_flag_oe = bus_active_reg;

  // Trigger levels and range are sampled for completeness of the synchronised view.
  wire unused_ok;
  assign unused_ok = trig_a_lvl & trig_b_lvl & range_sync_reg;
endmodule // simultaneous_sample_conv_control
`default_nettype wire

/* verilog/conv_ctrl_consts.vh */
// Constants for the simultaneous sampling conversion control block.
// Functional notes
// - Power-save low enters standby or shutdown by range.
// - Standby powers down front ends, keeps reference.
// - Power-down entry acts asynchronously at any time.
// - Common trigger rise holds all four channels.
// - Busy rises at conversion start, bounded duration.
// - Busy falls as results are latched, or on power-down without latching.
// - Falling strobe edges present channels ascending from one.
// - All four channels always converted and read.
// - First-channel flag high on first read only.
// - Strobes high end frame, bus and flag tri-state.
// - Trigger A holds channels 1-2, waits for B.
// - Trigger B holds channels 3-4.
// - Conversion starts after both trigger rising edges.
// - Trigger activity ignored while busy.
// - Read during busy returns previous results.
// - Flag leaves tri-state when chip select falls.
`ifndef CONV_CTRL_CONSTS_VH
`define CONV_CTRL_CONSTS_VH
`define CLK_FREQ_HZ 10000000
`define CONV_TIME_MAX_NS 3000
`define CONV_CYCLES ((`CONV_TIME_MAX_NS * (`CLK_FREQ_HZ / 1000000)) / 1000)
`define DATA_W 16
`define CH_COUNT 4
`define CH_IDX_W 2
`define CONV_CNT_W 8
`define CH_FIRST 2'h0
`define CH_LAST 2'h3
`define DATA_RST 16'h0000
`endif

/* verilog/edge_sync.v */
// Two-flop synchroniser with rising and falling edge pulses.
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
  input wire i_clk,
  input wire i_nrst,
  input wire i_rst_level,
  input wire i_async,
  output wire o_level,
  output wire o_rise,
  output wire o_fall
);
  reg meta_reg;
  reg sync_reg;
  reg last_reg;

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= i_async ^ i_rst_level;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // The flops hold the input relative to its idle level, so clearing them on reset never makes a false edge.
  assign o_level = sync_reg ^ i_rst_level;
  assign o_rise = (sync_reg ^ i_rst_level) & ~(last_reg ^ i_rst_level);
  assign o_fall = ~(sync_reg ^ i_rst_level) & (last_reg ^ i_rst_level);
endmodule // edge_sync
`default_nettype wire

/* verif/conv_ctrl_checker.sv */
// Checker of power-down, conversion and readout behaviour at the block ports.
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl_checker (
  input wire i_clk,
  input wire i_nrst,
  input wire i_power_save_n,
  input wire i_range,
  input wire i_cs_n,
  input wire i_rd_n,
  input wire o_standby,
  input wire o_hold_a,
  input wire o_hold_b,
  input wire o_busy,
  input wire o_parallel_out_bus_oe,
  input wire o_first_channel_flag,
  input wire o_first_channel_flag_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  property p_sby; o_standby == (!i_power_save_n && i_range); endproperty
  a_sby: assert property (p_sby) else $error("bad standby");
  property p_pd; !i_power_save_n [*4] |-> !o_busy && !o_hold_a && !o_hold_b; endproperty
  a_pd: assert property (p_pd) else $error("active in power-down");
  property p_start; $rose(o_busy) |-> o_hold_a && o_hold_b; endproperty
  a_start: assert property (p_start) else $error("busy before both holds");
  property p_len; $rose(o_busy) |-> ##[1:30] !o_busy; endproperty
  a_len: assert property (p_len) else $error("busy too long");
  property p_min; ($rose(o_busy) ##0 i_power_save_n [*8]) |-> o_busy; endproperty
  a_min: assert property (p_min) else $error("busy too short");
  property p_clr; $fell(o_busy) |-> !o_hold_a && !o_hold_b; endproperty
  a_clr: assert property (p_clr) else $error("hold after busy");
  property p_oe; (i_cs_n && i_rd_n) [*5] |-> !o_parallel_out_bus_oe && !o_first_channel_flag_oe; endproperty
  a_oe: assert property (p_oe) else $error("bus driven idle");
  property p_on; (!i_cs_n && !i_rd_n) [*5] |-> o_first_channel_flag_oe; endproperty
  a_on: assert property (p_on) else $error("flag not driven");
  c_busy: cover property ($rose(o_busy));
  c_flag: cover property ($rose(o_first_channel_flag));
  c_sby: cover property (o_standby);
endmodule // conv_ctrl_checker
bind simultaneous_sample_conv_control conv_ctrl_checker chk (.*);
`default_nettype wire

/* verif/host_model.sv */
// Host controller model driving the group triggers and the tied read strobe.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic i_clk,
  output logic o_trig_a,
  output logic o_trig_b,
  output logic o_strobe_n
);
  initial begin
    o_trig_a = 1'b0;
    o_trig_b = 1'b0;
    o_strobe_n = 1'b1;
  end
  // Both triggers pulsed together act as one common trigger.
  task automatic trig(input logic a, input logic b, input int w);
    o_trig_a = a;
    o_trig_b = b;
    repeat (w) @(negedge i_clk);
    o_trig_a = 1'b0;
    o_trig_b = 1'b0;
    repeat (w) @(negedge i_clk);
  endtask
  // Chip select and read strobe share one wire; raising it ends the frame.
  task automatic strobe(input logic lvl, input int w);
    o_strobe_n = lvl;
    repeat (w) @(negedge i_clk);
  endtask
endmodule // host_model
`default_nettype wire

/* verif/test_simultaneous_sample_conv_control.sv */
// Self-checking bench for the conversion control block.
`timescale 1ns/1ps
`default_nettype none
module test_simultaneous_sample_conv_control;
  logic clk, nrst, psn, rng, sby, sdn, fe, rf, ha, hb, busy, oe, flag, foe, ta, tb, sn;
  logic [15:0] bus;
  logic [15:0] d [4];
  logic [15:0] held [4];
  logic [15:0] prev [4];
  int n_mismatch = 0;
  int comparisons = 0;
  host_model h (.i_clk(clk), .o_trig_a(ta), .o_trig_b(tb), .o_strobe_n(sn));
  simultaneous_sample_conv_control dut (.i_clk(clk), .i_nrst(nrst), .i_power_save_n(psn), .i_range(rng),
    .i_sample_trigger_a(ta), .i_sample_trigger_b(tb), .i_cs_n(sn), .i_rd_n(sn), .i_ch1_data(d[0]),
    .i_ch2_data(d[1]), .i_ch3_data(d[2]), .i_ch4_data(d[3]), .o_standby(sby), .o_shutdown(sdn),
    .o_front_end_on(fe), .o_reference_on(rf), .o_hold_a(ha), .o_hold_b(hb), .o_busy(busy),
    .o_parallel_out_bus(bus), .o_parallel_out_bus_oe(oe), .o_first_channel_flag(flag),
    .o_first_channel_flag_oe(foe));
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] exp_ch(input int k, input logic old);
    return old ? prev[k] : held[k];
  endfunction
  task automatic rst_pulse;
    nrst = 1'b0;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
  endtask
  task automatic wait_idle;
    for (int n = 0; n < 40 && busy !== 1'b0; n++)
      @(negedge clk);
    chk(busy, 0);
  endtask
  // Triggers a conversion; data inputs change after each group is held.
  task automatic conv(input logic sep, input int w);
    prev = held;
    foreach (d[k]) d[k] = $urandom;
    held = d;
    h.trig(1'b1, !sep, w);
    foreach (d[k]) d[k] = $urandom;
    if (sep) begin
      chk({ha, hb, busy}, 3'h4);
      held[2] = d[2];
      held[3] = d[3];
      h.trig(1'b0, 1'b1, w);
      foreach (d[k]) d[k] = $urandom;
    end
    chk({ha, hb, busy}, 3'h7);
  endtask
  task automatic read_all(input int w, input logic old);
    for (int k = 0; k < 4; k++) begin
      h.strobe(1'b0, w);
      chk(bus, exp_ch(k, old));
      chk({oe, foe, flag}, {2'h3, k == 0});
      h.strobe(1'b1, w);
    end
    h.strobe(1'b1, 3);
    chk({oe, foe}, 0);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #1000000;
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    void'($urandom(94469));
    psn = 1'b1;
    rng = 1'b1;
    foreach (d[k]) d[k] = 16'h0000;
    rst_pulse;
    repeat (4) begin
      conv($urandom % 2, 4);
      wait_idle;
      read_all(5, 1'b0);
    end
    $display("random conversions done");
    conv(1'b0, 2);
    read_all(4, 1'b1);
    wait_idle;
    read_all(5, 1'b0);
    $display("read during busy done");
    conv(1'b1, 4);
    h.trig(1'b1, 1'b1, 4);
    wait_idle;
    repeat (10) @(negedge clk);
    chk({busy, ha, hb}, 0);
    read_all(5, 1'b0);
    $display("busy trigger ignore done");
    psn = 1'b0;
    @(negedge clk);
    chk({sby, sdn, fe, rf}, 4'h9);
    rng = 1'b0;
    h.trig(1'b1, 1'b1, 4);
    chk({sby, sdn, fe, rf, busy, ha}, 6'h10);
    psn = 1'b1;
    repeat (200) @(negedge clk); // Shortened shutdown wake wait.
    rst_pulse;
    conv(1'b0, 4);
    rng = 1'b1;
    psn = 1'b0;
    repeat (5) @(negedge clk);
    chk({busy, ha, hb}, 0);
    psn = 1'b1;
    repeat (1000) @(negedge clk);
    conv(1'b1, 4);
    wait_idle;
    read_all(5, 1'b0);
    $display("power-down done");
    report_and_stop;
  end
endmodule // test_simultaneous_sample_conv_control
`default_nettype wire
